// ===== core/uotg_cfg.svh
// Constants of the dual-role port status and control block.
// Assumes a 10 MHz module clock and a 16-bit register port with 8-bit addresses.
`ifndef UOTG_CFG_SVH
`define UOTG_CFG_SVH

// Register byte offsets
`define UOTG_OFS_STAT 8'h00
`define UOTG_OFS_CTRL 8'h04
`define UOTG_OFS_IFLG 8'h08
`define UOTG_OFS_IMSK 8'h0C
`define UOTG_OFS_MODE 8'h10

// Status field positions
`define UOTG_ST_PLUG 7
`define UOTG_ST_LINE 5
`define UOTG_ST_SESVLD 3
`define UOTG_ST_SESSION_END_FLAG 2
`define UOTG_ST_AVALID 0
`define UOTG_ST_IMPL 8'hAD

// Control field positions
`define UOTG_CT_DPPU 7
`define UOTG_CT_DMPU 6
`define UOTG_CT_DPPD 5
`define UOTG_CT_DMPD 4
`define UOTG_CT_PWRON 3
`define UOTG_CT_DUAL 2
`define UOTG_CT_CHG 1
`define UOTG_CT_DIS 0

// Mode field positions
`define UOTG_MD_HOST 3
`define UOTG_MD_USB_MODULE_ENABLE 0
`define UOTG_MD_IMPL 8'h09

// Reset values
`define UOTG_CTRL_RST 8'h00
`define UOTG_MODE_RST 8'h00
`define UOTG_STAT_RST 8'h00
`define UOTG_IFLG_RST 8'h00
`define UOTG_IMSK_RST 8'h00

// Timing
`define UOTG_CLK_HZ 10000000
`define UOTG_STABLE_TIME_MS 1
`define UOTG_US_CYCLES (`UOTG_CLK_HZ / 1000000)
`define UOTG_STABLE_US (`UOTG_STABLE_TIME_MS * 1000)

`endif

// ===== core/uotg_pkg.sv
// Types shared by the dual-role port status and control block.
// Assumes the constants of uotg_cfg.svh are included where numbers are needed.
package uotg_pkg;
    typedef logic [15:0] uotg_word_t;
    typedef logic [7:0] uotg_byte_t;
    typedef logic [7:0] uotg_addr_t;
    // Line timer states
    typedef enum logic {
        UOTG_LST_COUNT = 1'b0,
        UOTG_LST_STABLE = 1'b1
    } uotg_lst_t;
endpackage

// ===== core/uotg_line_timer.sv
// Line-state stability timer: flags a bus line state unchanged for the stable time.
// Assumes lineState is already synchronised to clk.
`timescale 1ns/1ps
`include "uotg_cfg.svh"
module uotg_line_timer
    import uotg_pkg::*;
#(
    parameter int US_CYCLES = `UOTG_US_CYCLES,
    parameter int STABLE_US = `UOTG_STABLE_US
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [1:0] lineState,
    output logic stable
);
    logic [1:0] prevLine_r, prevLine_nxt;
    logic [7:0] pre_r, pre_nxt;
    logic [15:0] usCnt_r, usCnt_nxt;
    uotg_lst_t state_r, state_nxt;
    logic usTick;

    // Microsecond enable pulse; restarts with the count so the window is exact
    always_comb begin
        prevLine_nxt = lineState;
        usTick = (pre_r == 8'(US_CYCLES - 1));
        pre_nxt = usTick ? 8'h00 : pre_r + 8'h01;
        usCnt_nxt = usCnt_r;
        state_nxt = state_r;
        if (lineState != prevLine_r) begin
            pre_nxt = 8'h00; // RULE11
            usCnt_nxt = 16'h0000;
            state_nxt = UOTG_LST_COUNT; // RULE5
        end else begin
            unique case (state_r)
                UOTG_LST_COUNT: begin
                    if (usTick) begin
                        usCnt_nxt = usCnt_r + 16'h0001;
                        if (usCnt_r == 16'(STABLE_US - 1)) begin
                            state_nxt = UOTG_LST_STABLE; // RULE11
                        end
                    end
                end
                UOTG_LST_STABLE: begin
                    usCnt_nxt = usCnt_r; // Held until the next change
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            prevLine_r <= 2'b00;
            pre_r <= 8'h00;
            usCnt_r <= 16'h0000;
            state_r <= UOTG_LST_COUNT;
        end else begin
            prevLine_r <= prevLine_nxt;
            pre_r <= pre_nxt;
            usCnt_r <= usCnt_nxt;
            state_r <= state_nxt;
        end
    end

    assign stable = (state_r == UOTG_LST_STABLE);
endmodule

// ===== core/uotg_status_control.sv
// Dual-role port status and control registers with line-stable timer and interrupt.
// Assumes a plain register port on clk, comparator and cable pins from outside clk.
// Contract
// RULE1 - Status register reads only while host role enabled; otherwise zero.
// RULE2 - Upper byte and bits 6, 4, 1 of status read zero; writes ignored.
// RULE3 - Status bits are hardware-driven, read-only, zero after reset.
// RULE4 - Bit 7 one for no plug or B cable, zero for A plug.
// RULE5 - Bit 5 set when line state unchanged for previous 1 ms.
// RULE6 - Bit 3 set while supply above session-valid threshold.
// RULE7 - Bit 2 set while supply below B session-end threshold.
// RULE8 - Bit 0 set while supply above A supply-valid threshold.
// RULE9 - Pull-up control bits enable D- and D+ pull-ups directly.
// RULE10 - Dual-role enable gives software the pulls; else derived from role enables.
// RULE11 - Stability counter restarts on line change, flags at one millisecond.
`timescale 1ns/1ps
`include "uotg_cfg.svh"
module uotg_status_control
    import uotg_pkg::*;
#(
    parameter int STABLE_US = `UOTG_STABLE_US
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdata,
    input wire logic idPin,
    input wire logic se0Det,
    input wire logic jStateDet,
    input wire logic sessionValidCmp,
    input wire logic sessionEndCmp,
    input wire logic supplyValidCmp,
    output logic dplusPullupEn,
    output logic dminusPullupEn,
    output logic dplusPulldownEn,
    output logic dminusPulldownEn,
    output logic busPowerOn,
    output logic busChargeSel,
    output logic busDischargeEn,
    output logic irq
);
    // Pin vector order, lowest bit first: supply valid, session end, session valid, J, SE0, id
    localparam int NPIN = 6;
    localparam int P_SUPPLY = 0;
    localparam int P_SESSION_END_FLAG = 1;
    localparam int P_SESVLD = 2;
    localparam int P_JSTATE = 3;
    localparam int P_SE0 = 4;
    localparam int P_ID = 5;

    // Synchroniser stages and debounced pin levels
    logic [NPIN-1:0] pinRaw;
    logic [NPIN-1:0] sync1_r, sync1_nxt;
    logic [NPIN-1:0] sync2_r, sync2_nxt;
    logic [NPIN-1:0] sync3_r, sync3_nxt;
    logic [NPIN-1:0] filt_r, filt_nxt;
    logic lineStable;

    // Register file and registered read data
    uotg_byte_t stat_r, stat_nxt;
    uotg_byte_t ctrl_r, ctrl_nxt;
    uotg_byte_t mode_r, mode_nxt;
    uotg_byte_t iflg_r, iflg_nxt;
    uotg_byte_t imsk_r, imsk_nxt;
    uotg_word_t rdata_r, rdata_nxt;
    logic irq_r, irq_nxt;

    // Output flops: pulls follow control in dual-role mode, else the role; supply switches copy control
    logic dpPu_r, dpPu_nxt;
    logic dmPu_r, dmPu_nxt;
    logic dpPd_r, dpPd_nxt;
    logic dmPd_r, dmPd_nxt;
    logic pwrOn_r, pwrOn_nxt;
    logic chg_r, chg_nxt;
    logic dis_r, dis_nxt;

    // Decode results and event terms
    logic hitStat, hitCtrl, hitIflg, hitImsk, hitMode;
    logic wrCtrl, wrMode, wrImsk, wrIflg;
    logic hostRole, usbOn, dualRole;
    uotg_byte_t statEvent;
    uotg_byte_t iflgClr;

    assign pinRaw = {idPin, se0Det, jStateDet, sessionValidCmp, sessionEndCmp, supplyValidCmp};

    // Three-stage synchroniser; stage one feeds only stage two
    always_comb begin
        sync1_nxt = pinRaw;
        sync2_nxt = sync1_r;
        sync3_nxt = sync2_r;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sync1_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
        end else begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
            sync3_r <= sync3_nxt;
        end
    end

    // A pin change counts only once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_filt
            always_comb begin
                filt_nxt[gi] = (sync2_r[gi] == sync3_r[gi]) ? sync3_r[gi] : filt_r[gi];
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            filt_r <= '0;
        end else begin
            filt_r <= filt_nxt;
        end
    end

    // Stability of the SE0/J line state pair
    uotg_line_timer #(
        .US_CYCLES(`UOTG_US_CYCLES),
        .STABLE_US(STABLE_US)
    ) u_line_timer (
        .clk(clk),
        .rst_b(rst_b),
        .lineState({filt_r[P_SE0], filt_r[P_JSTATE]}),
        .stable(lineStable)
    );

    // Address decode
    always_comb begin
        hitStat = (regAddr == `UOTG_OFS_STAT);
        hitCtrl = (regAddr == `UOTG_OFS_CTRL);
        hitIflg = (regAddr == `UOTG_OFS_IFLG);
        hitImsk = (regAddr == `UOTG_OFS_IMSK);
        hitMode = (regAddr == `UOTG_OFS_MODE);
        wrCtrl = regWr && hitCtrl;
        wrMode = regWr && hitMode;
        wrImsk = regWr && hitImsk;
        wrIflg = regWr && hitIflg;
        hostRole = mode_r[`UOTG_MD_HOST];
        usbOn = mode_r[`UOTG_MD_USB_MODULE_ENABLE];
        dualRole = ctrl_r[`UOTG_CT_DUAL];
    end

    // Status tracks the filtered pins; software cannot write it
    always_comb begin
        stat_nxt = `UOTG_STAT_RST; // RULE2
        stat_nxt[`UOTG_ST_PLUG] = filt_r[P_ID]; // RULE4
        stat_nxt[`UOTG_ST_LINE] = lineStable; // RULE5
        stat_nxt[`UOTG_ST_SESVLD] = filt_r[P_SESVLD]; // RULE6
        stat_nxt[`UOTG_ST_SESSION_END_FLAG] = filt_r[P_SESSION_END_FLAG]; // RULE7
        stat_nxt[`UOTG_ST_AVALID] = filt_r[P_SUPPLY]; // RULE8
    end

    // Status register; the read mux sees only this copy
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stat_r <= `UOTG_STAT_RST; // RULE3
        end else begin
            stat_r <= stat_nxt; // RULE3
        end
    end

    // Software-written control and role registers
    always_comb begin
        ctrl_nxt = ctrl_r;
        mode_nxt = mode_r;
        imsk_nxt = imsk_r;
        if (wrCtrl) begin
            ctrl_nxt = regWdata[7:0];
        end
        if (wrMode) begin
            mode_nxt = regWdata[7:0] & `UOTG_MD_IMPL;
        end
        if (wrImsk) begin
            imsk_nxt = regWdata[7:0] & `UOTG_ST_IMPL;
        end
    end

    // Software registers clear on reset only
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ctrl_r <= `UOTG_CTRL_RST;
            mode_r <= `UOTG_MODE_RST;
            imsk_r <= `UOTG_IMSK_RST;
        end else begin
            ctrl_r <= ctrl_nxt;
            mode_r <= mode_nxt;
            imsk_r <= imsk_nxt;
        end
    end

    // Any status edge is an event; writing a one clears its flag
    always_comb begin
        statEvent = (stat_nxt ^ stat_r) & `UOTG_ST_IMPL;
        iflgClr = wrIflg ? regWdata[7:0] : 8'h00;
    end

    // One sticky flag per status bit; a set in the clearing cycle wins so no edge is lost
    genvar fi;
    generate
        for (fi = 0; fi < 8; fi++) begin : g_flag
            always_comb begin
                if (statEvent[fi]) begin
                    iflg_nxt[fi] = 1'b1;
                end else if (iflgClr[fi]) begin
                    iflg_nxt[fi] = 1'b0;
                end else begin
                    iflg_nxt[fi] = iflg_r[fi];
                end
            end
        end
    endgenerate

    // Interrupt follows the next flags so it rises with them
    always_comb begin
        irq_nxt = |(iflg_nxt & imsk_nxt);
    end

    // Flags and interrupt registered together
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            iflg_r <= `UOTG_IFLG_RST;
            irq_r <= 1'b0;
        end else begin
            iflg_r <= iflg_nxt;
            irq_r <= irq_nxt;
        end
    end

    // Pull resistors: software direct in dual-role mode, else by role
    always_comb begin
        if (dualRole) begin
            dpPu_nxt = ctrl_r[`UOTG_CT_DPPU]; // RULE9
            dmPu_nxt = ctrl_r[`UOTG_CT_DMPU]; // RULE9
            dpPd_nxt = ctrl_r[`UOTG_CT_DPPD]; // RULE10
            dmPd_nxt = ctrl_r[`UOTG_CT_DMPD]; // RULE10
        end else if (hostRole) begin
            // Host holds both lines low so an attach can be seen
            dpPu_nxt = 1'b0; // RULE10
            dmPu_nxt = 1'b0;
            dpPd_nxt = 1'b1;
            dmPd_nxt = 1'b1;
        end else if (usbOn) begin
            // Peripheral connects as full speed on D+
            dpPu_nxt = 1'b1; // RULE10
            dmPu_nxt = 1'b0;
            dpPd_nxt = 1'b0;
            dmPd_nxt = 1'b0;
        end else begin
            dpPu_nxt = 1'b0; // RULE10
            dmPu_nxt = 1'b0;
            dpPd_nxt = 1'b0;
            dmPd_nxt = 1'b0;
        end
    end

    // Pull flops; outputs lag the control write by one edge
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            dpPu_r <= 1'b0;
            dmPu_r <= 1'b0;
            dpPd_r <= 1'b0;
            dmPd_r <= 1'b0;
        end else begin
            dpPu_r <= dpPu_nxt;
            dmPu_r <= dmPu_nxt;
            dpPd_r <= dpPd_nxt;
            dmPd_r <= dmPd_nxt;
        end
    end

    // Supply switches copy control in every role; software owns the power sequencing
    always_comb begin
        pwrOn_nxt = ctrl_r[`UOTG_CT_PWRON];
        chg_nxt = ctrl_r[`UOTG_CT_CHG];
        dis_nxt = ctrl_r[`UOTG_CT_DIS];
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pwrOn_r <= 1'b0;
            chg_r <= 1'b0;
            dis_r <= 1'b0;
        end else begin
            pwrOn_r <= pwrOn_nxt;
            chg_r <= chg_nxt;
            dis_r <= dis_nxt;
        end
    end

    // Read data stand for one cycle only; unmapped reads give zero
    always_comb begin
        rdata_nxt = 16'h0000;
        if (regRd) begin
            if (hitStat && hostRole) begin
                rdata_nxt = {8'h00, stat_r & `UOTG_ST_IMPL}; // RULE1
            end else if (hitCtrl) begin
                rdata_nxt = {8'h00, ctrl_r};
            end else if (hitIflg) begin
                rdata_nxt = {8'h00, iflg_r};
            end else if (hitImsk) begin
                rdata_nxt = {8'h00, imsk_r};
            end else if (hitMode) begin
                rdata_nxt = {8'h00, mode_r};
            end
        end
    end

    // Read data register; zero between reads
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rdata_r <= 16'h0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // Every output straight from a flop
    assign regRdata = rdata_r;

    // Level interrupt
    assign irq = irq_r;

    // Line pulls
    assign dplusPullupEn = dpPu_r;
    assign dminusPullupEn = dmPu_r;
    assign dplusPulldownEn = dpPd_r;
    assign dminusPulldownEn = dmPd_r;

    // Supply switches
    assign busPowerOn = pwrOn_r;
    assign busChargeSel = chg_r;
    assign busDischargeEn = dis_r;
endmodule

// ===== dv/uotg_sc_chk.sv
// Port checker for the dual-role status and control block.
// Assumes it is bound to uotg_status_control and sees only its ports.
`timescale 1ns/1ps
module uotg_sc_chk #(
    parameter int STABLE_US = 1000
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [15:0] regRdata,
    input wire logic idPin,
    input wire logic se0Det,
    input wire logic jStateDet,
    input wire logic sessionValidCmp,
    input wire logic sessionEndCmp,
    input wire logic supplyValidCmp,
    input wire logic dplusPullupEn,
    input wire logic dminusPullupEn,
    input wire logic dplusPulldownEn,
    input wire logic dminusPulldownEn,
    input wire logic busPowerOn,
    input wire logic busChargeSel,
    input wire logic busDischargeEn,
    input wire logic irq
);
    logic [7:0] ctl_r;
    logic [7:0] mode_r;
    logic [1:0] line_r;
    logic [3:0] pin_r;
    logic rdAny_r;
    logic rdStat_r;
    logic host_r;
    int lineCnt_r;
    int pinCnt_r;
    wire [3:0] pulls = {dplusPullupEn, dminusPullupEn, dplusPulldownEn, dminusPulldownEn};
    wire [3:0] pins = {idPin, sessionValidCmp, sessionEndCmp, supplyValidCmp};
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    // Write shadows and quiet counters; counters saturate so they never wrap
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ctl_r <= 8'h00;
            mode_r <= 8'h00;
            line_r <= 2'b00;
            pin_r <= 4'h0;
            rdAny_r <= 1'b0;
            rdStat_r <= 1'b0;
            host_r <= 1'b0;
            lineCnt_r <= 0;
            pinCnt_r <= 0;
        end else begin
            if (regWr && regAddr == 8'h04) ctl_r <= regWdata[7:0];
            if (regWr && regAddr == 8'h10) mode_r <= regWdata[7:0];
            line_r <= {se0Det, jStateDet};
            pin_r <= pins;
            rdAny_r <= regRd;
            rdStat_r <= regRd && regAddr == 8'h00;
            host_r <= mode_r[3];
            lineCnt_r <= ({se0Det, jStateDet} != line_r) ? 0 : (lineCnt_r < 99999 ? lineCnt_r + 1 : lineCnt_r);
            pinCnt_r <= (pins != pin_r) ? 0 : (pinCnt_r < 99 ? pinCnt_r + 1 : pinCnt_r);
        end
    end

    a_rdata_idle: assert property (!rdAny_r |-> regRdata == 16'h0000) else $error("read data not idle");
    a_stat_unused: assert property (rdStat_r |-> (regRdata & 16'hFF52) == 16'h0000)
        else $error("unused status bit set");
    a_stat_gate: assert property (rdStat_r && !host_r |-> regRdata == 16'h0000)
        else $error("status seen outside host role");
    a_plug_level: assert property (rdStat_r && host_r && pinCnt_r > 8 && pins == pin_r
        |-> regRdata[7] == idPin) else $error("plug bit wrong");
    a_supply_bits: assert property (rdStat_r && host_r && pinCnt_r > 8 && pins == pin_r
        |-> regRdata[3:0] == {sessionValidCmp, sessionEndCmp, 1'b0, supplyValidCmp}) else $error("supply bits wrong");
    a_line_early: assert property (rdStat_r && host_r && regRdata[5] |-> lineCnt_r >= STABLE_US * 10)
        else $error("line stable too early");
    a_line_sets: assert property (rdStat_r && host_r && lineCnt_r > STABLE_US * 10 + 10 |-> regRdata[5])
        else $error("line stable missing");
    a_pull_direct: assert property (ctl_r[2] && $stable(ctl_r)
        |-> {pulls, busPowerOn, busChargeSel, busDischargeEn} == {ctl_r[7:3], ctl_r[1:0]}) else $error("pull copy wrong");
    a_pull_host: assert property (!ctl_r[2] && mode_r[3] && $stable(ctl_r) && $stable(mode_r)
        |-> pulls == 4'b0011) else $error("host pulls wrong");

    cover property (rdStat_r && host_r && regRdata[5]);
    cover property (rdStat_r && host_r && !regRdata[7]);
    cover property ($rose(irq));
endmodule

bind uotg_status_control uotg_sc_chk #(.STABLE_US(STABLE_US)) u_uotg_sc_chk (.*);

// ===== dv/uotg_cable_model.sv
// Cable, transceiver and supply comparators facing the status block.
// Assumes the bench picks plug kind and supply level; line follows pull-ups.
`timescale 1ns/1ps
module uotg_cable_model (
    input wire logic plugA,
    input wire logic [1:0] vbusLvl,
    input wire logic dplusPullupEn,
    input wire logic dminusPullupEn,
    output logic idPin,
    output logic se0Det,
    output logic jStateDet,
    output logic sessionValidCmp,
    output logic sessionEndCmp,
    output logic supplyValidCmp
);
    // Only an A plug grounds the id pin
    assign idPin = !plugA;
    // Supply levels 0..3: below end, between, session valid, supply valid
    assign sessionEndCmp = vbusLvl == 2'd0;
    assign sessionValidCmp = vbusLvl[1];
    assign supplyValidCmp = vbusLvl == 2'd3;
    // No pull-up leaves both lines low; a D+ pull-up gives J
    assign se0Det = !(dplusPullupEn || dminusPullupEn);
    assign jStateDet = dplusPullupEn;
endmodule

// ===== dv/tb.sv
// Self-checking bench for the dual-role status and control block.
// Assumes a cable model on the pins and software on the register port.
`timescale 1ns/1ps
module tb;
    import uotg_pkg::*;
    localparam int SUS = 5;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic plugA = 1'b0;
    logic [1:0] vbusLvl = 2'd0;
    uotg_addr_t regAddr = 8'h00;
    uotg_word_t regWdata = 16'h0000;
    uotg_word_t regRdata, d;
    logic idPin, se0Det, jStateDet, sessionValidCmp, sessionEndCmp, supplyValidCmp, irq;
    logic dplusPullupEn, dminusPullupEn, dplusPulldownEn, dminusPulldownEn, busPowerOn, busChargeSel, busDischargeEn;
    wire [3:0] pulls = {dplusPullupEn, dminusPullupEn, dplusPulldownEn, dminusPulldownEn};
    int n_fail = 0;
    int samples_checked = 0;
    int cyc = 0;

    uotg_status_control #(.STABLE_US(SUS)) u_uotg_status_control (.*);
    uotg_cable_model u_uotg_cable_model (.*);

    always #50 clk = ~clk;

    // Hang guard: the sequence needs well under a thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            test_done();
        end
    end

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input uotg_word_t exp, input uotg_word_t got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input uotg_addr_t a, input uotg_word_t v);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= v;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input uotg_addr_t a);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask

    // Host role first so the status read is not gated to zero
    task automatic t_reset();
        wr(8'h10, 16'h0008);
        rd(8'h00);
        chk("statusAtReset", 16'h0000, d);
        rd(8'h04);
        chk("controlAtReset", 16'h0000, d);
        rd(8'h20);
        chk("unmapped", 16'h0000, d);
    endtask

    task automatic t_host();
        wr(8'h10, 16'h0008);
        wr(8'h00, 16'hFFFF);
        repeat (8) @(posedge clk);
        rd(8'h00);
        chk("statusHost", 16'h0084, d & 16'hFFDF);
        wr(8'h10, 16'h0000);
        rd(8'h00);
        chk("statusDevice", 16'h0000, d);
        wr(8'h10, 16'h0008);
    endtask

    task automatic t_levels();
        uotg_word_t e;
        for (int p = 0; p < 2; p++) begin
            for (int l = 0; l < 4; l++) begin
                plugA <= p[0];
                vbusLvl <= l[1:0];
                repeat (8) @(posedge clk);
                rd(8'h00);
                e = {8'h00, !p[0], 3'b000, l[1], l == 0, 1'b0, l == 3};
                chk("statusLevels", e, d & 16'hFFDF);
            end
        end
    endtask

    // Each control bit alone with the dual-role bit; upper byte must not stick
    task automatic t_pulls();
        uotg_word_t v;
        for (int i = 0; i < 8; i++) begin
            v = 16'h0004 | (16'h0001 << i);
            wr(8'h04, v | 16'hFF00);
            rd(8'h04);
            chk("controlBack", v, d);
            chk("pullOut", {12'h000, v[7:4]}, {12'h000, pulls});
            chk("powerOut", {13'h0000, v[3], v[1:0]}, {13'h0000, busPowerOn, busChargeSel, busDischargeEn});
        end
        wr(8'h04, 16'h0000);
        repeat (3) @(posedge clk);
        chk("pullHost", 16'h0003, {12'h000, pulls});
        wr(8'h10, 16'h0001);
        repeat (3) @(posedge clk);
        chk("pullEnabled", 16'h0008, {12'h000, pulls});
        wr(8'h10, 16'h0000);
        repeat (3) @(posedge clk);
        chk("pullOff", 16'h0000, {12'h000, pulls});
    endtask

    task automatic t_line();
        wr(8'h10, 16'h0008);
        wr(8'h04, 16'h0084);
        repeat (10) @(posedge clk);
        rd(8'h00);
        chk("lineEarly", 16'h0000, d & 16'h0020);
        repeat (SUS * 10 + 5) @(posedge clk);
        rd(8'h00);
        chk("lineStable", 16'h0020, d & 16'h0020);
        wr(8'h04, 16'h0044);
        repeat (8) @(posedge clk);
        rd(8'h00);
        chk("lineRestart", 16'h0000, d & 16'h0020);
    endtask

    task automatic t_irq();
        vbusLvl <= 2'd0;
        repeat (8) @(posedge clk);
        wr(8'h08, 16'h00FF);
        wr(8'h0C, 16'h0001);
        repeat (2) @(posedge clk);
        chk("irqIdle", 16'h0000, {15'h0000, irq});
        vbusLvl <= 2'd3;
        repeat (8) @(posedge clk);
        chk("irqRaised", 16'h0001, {15'h0000, irq});
        wr(8'h08, 16'h0001);
        repeat (2) @(posedge clk);
        chk("irqCleared", 16'h0000, {15'h0000, irq});
        wr(8'h0C, 16'h0000);
        vbusLvl <= 2'd0;
        repeat (8) @(posedge clk);
        chk("irqMasked", 16'h0000, {15'h0000, irq});
        rd(8'h08);
        chk("flagSet", 16'h0001, d & 16'h0001);
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_host();
        t_levels();
        t_pulls();
        t_line();
        t_irq();
        test_done();
    end
endmodule
